// ==== srp_pkg.sv ====
// constants and types shared by the shift register port
package srp_pkg;
   localparam int unsigned CLK_KHZ = 50000;
   localparam int unsigned SCLK_MIN_KHZ = 150;
   localparam int unsigned XFER_MAX_US = 215;
   localparam int unsigned XFER_REF_BITS = 32;
   localparam int unsigned HALF_MAX_CYC = CLK_KHZ / (2 * SCLK_MIN_KHZ);
   localparam logic [7:0] HALF_MAX = HALF_MAX_CYC[7:0];
   localparam logic [7:0] HALF_MIN = 8'h04;
   localparam logic [7:0] DIV_RST = 8'h19;

   localparam int unsigned DATA_W = 32;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned MEM_WORDS = 8;
   localparam logic [8:0] LEN_MAX = 9'h100;
   localparam logic [8:0] LEN_MIN = 9'h001;
   localparam logic [8:0] LEN_RST = 9'h020;

   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_OUT_CFG = 12'h004;
   localparam logic [11:0] OFF_IN_CFG = 12'h008;
   localparam logic [11:0] OFF_OUT_DATA = 12'h00C;
   localparam logic [11:0] OFF_DIV = 12'h010;
   localparam logic [11:0] OFF_IN_DATA = 12'h020;

   localparam int unsigned CTRL_WR_BIT = 0;
   localparam int unsigned CTRL_RD_BIT = 1;
   localparam int unsigned STAT_BUSY_BIT = 2;
   localparam int unsigned STAT_EMPTY_BIT = 3;
   localparam int unsigned CFG_STYLE_BIT = 16;

   typedef enum logic {
      rising_clock_rising_latch_style = 1'b0,
      rising_clock_low_capture_style = 1'b1
   } srp_style_t;

   typedef enum logic [5:0] {
      S_IDLE = 6'b000001,
      S_FETCH = 6'b000010,
      S_LOW = 6'b000100,
      S_HIGH = 6'b001000,
      S_STROBE = 6'b010000,
      S_LOAD = 6'b100000
   } srp_state_t;
endpackage

// ==== srp_stream_if.sv ====
// valid/ready word stream between the port and its fifo
`timescale 1ns/1ps
interface srp_stream_if #(parameter int unsigned W = 32);
   logic [W-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// ==== srp_fifo.sv ====
// output word fifo with parameter width and depth
`timescale 1ns/1ps
module srp_fifo #(
   parameter int unsigned W = 32,
   parameter int unsigned D = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   srp_stream_if.snk in_s,
   srp_stream_if.src out_s
);
   localparam int unsigned AW = $clog2(D);
   logic [W-1:0] mem_r [D];
   logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic full, empty;

   assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
   assign empty = (wp_r == rp_r);
   assign in_s.ready = !full;
   assign out_s.valid = !empty;
   assign out_s.data = mem_r[rp_r[AW-1:0]];

   always_comb begin
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      if (in_s.valid && !full) begin
         wp_nxt = wp_r + {{AW{1'b0}}, 1'b1};
      end
      if (out_s.ready && !empty) begin
         rp_nxt = rp_r + {{AW{1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end

   always_ff @(posedge pclk) begin
      if (in_s.valid && !full) begin
         mem_r[wp_r[AW-1:0]] <= in_s.data;
      end
   end
endmodule

// ==== srp_mem.sv ====
// small input word memory with registered read data
`timescale 1ns/1ps
module srp_mem #(
   parameter int unsigned W = 32,
   parameter int unsigned N = 8
) (
   input wire logic pclk,
   input wire logic we,
   input wire logic [$clog2(N)-1:0] waddr,
   input wire logic [W-1:0] wdata,
   input wire logic [$clog2(N)-1:0] raddr,
   output logic [W-1:0] rdata
);
   logic [W-1:0] mem_r [N];

   always_ff @(posedge pclk) begin
      if (we) begin
         mem_r[waddr] <= wdata;
      end
      rdata <= mem_r[raddr];
   end
endmodule

// ==== srp_port.sv ====
// shift register chain port with apb register access
//
// Notes on behaviour
// - input and output chains are each up to 256 bits long.
// - each direction has its own strobe style, rising latch or low capture.
// - the style decides the strobe edge or level used when shifting out and in.
// - chain length and style are set apart per direction and may change between transfers.
// - a requested transfer runs to its end with all clock and strobe activity generated here.
// - the chain is only clocked after a write-chain or read-chain request.
// - the shift clock never runs slower than 150 kHz; the port holds it low in S_FETCH while the output fifo is empty.
// - a 32-bit transfer with its strobes ends within 215 us.
// - output bits leave most significant bit first.
// - a dedicated input load strobe tells the input chain when to capture.
// - one shift clock output serves both chains.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module srp_port (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic chain_sclk,
   output logic chain_sdo,
   output logic chain_out_latch,
   input wire logic chain_sdi,
   output logic chain_in_load
);
   import srp_pkg::*;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      return a == off;
   endfunction

   function automatic logic [8:0] clamp_len(input logic [31:0] v);
      if (v[8:0] == 9'h000) begin
         return LEN_MIN;
      end else if (v[8:0] > LEN_MAX) begin
         return LEN_MAX;
      end else begin
         return v[8:0];
      end
   endfunction

   function automatic logic [7:0] clamp_div(input logic [31:0] v);
      if (v[7:0] < HALF_MIN) begin
         return HALF_MIN;
      end else if (v[7:0] > HALF_MAX) begin
         return HALF_MAX;
      end else begin
         return v[7:0];
      end
   endfunction

   srp_stream_if #(.W(DATA_W)) wr_s ();
   srp_stream_if #(.W(DATA_W)) rd_s ();

   srp_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .in_s(wr_s),
      .out_s(rd_s)
   );

   // apb decode
   logic access, is_mem, mapped, wr_fire;
   logic [31:0] mem_rdata;
   assign access = psel && penable;
   assign is_mem = (paddr[11:5] == OFF_IN_DATA[11:5]);
   assign mapped = hit(paddr, OFF_CTRL) || hit(paddr, OFF_OUT_CFG) || hit(paddr, OFF_IN_CFG)
                   || hit(paddr, OFF_OUT_DATA) || hit(paddr, OFF_DIV) || is_mem;

   // register group
   logic [8:0] out_len_r, out_len_nxt, in_len_r, in_len_nxt;
   srp_style_t out_style_r, out_style_nxt, in_style_r, in_style_nxt;
   logic [7:0] div_r, div_nxt;
   logic wr_pend_r, wr_pend_nxt, rd_pend_r, rd_pend_nxt;
   logic rd_wait_r, rd_wait_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic start_wr, start_rd;

   // engine group
   srp_state_t st_r, st_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic [8:0] left_r, left_nxt;
   logic [4:0] wcnt_r, wcnt_nxt;
   logic [2:0] widx_r, widx_nxt;
   logic [31:0] word_r, word_nxt;
   logic dir_in_r, dir_in_nxt;
   srp_style_t sty_r, sty_nxt;
   logic sclk_r, sclk_nxt, sdo_r, sdo_nxt, olat_r, olat_nxt, iload_r, iload_nxt;
   logic sdi_m_r, sdi_s_r;
   logic tick, mem_we;

   // reads always take one wait state so prdata comes from a flop
   assign pready = access && (pwrite ? (!hit(paddr, OFF_OUT_DATA) || wr_s.ready) : rd_wait_r);
   assign pslverr = access && !mapped;
   assign prdata = prdata_r;
   assign wr_fire = access && pwrite && pready && mapped;
   assign wr_s.valid = access && pwrite && hit(paddr, OFF_OUT_DATA);
   assign wr_s.data = pwdata;

   always_comb begin
      out_len_nxt = out_len_r;
      out_style_nxt = out_style_r;
      in_len_nxt = in_len_r;
      in_style_nxt = in_style_r;
      div_nxt = div_r;
      prdata_nxt = prdata_r;
      rd_wait_nxt = access && !pwrite && !rd_wait_r;
      wr_pend_nxt = wr_pend_r && !start_wr;
      rd_pend_nxt = rd_pend_r && !start_rd;
      if (wr_fire) begin
         if (hit(paddr, OFF_CTRL)) begin
            // request set wins over the engine taking it
            if (pwdata[CTRL_WR_BIT]) begin
               wr_pend_nxt = 1'b1;
            end
            if (pwdata[CTRL_RD_BIT]) begin
               rd_pend_nxt = 1'b1;
            end
         end
         if (hit(paddr, OFF_OUT_CFG)) begin
            out_len_nxt = clamp_len(pwdata);
            out_style_nxt = srp_style_t'(pwdata[CFG_STYLE_BIT]);
         end
         if (hit(paddr, OFF_IN_CFG)) begin
            in_len_nxt = clamp_len(pwdata);
            in_style_nxt = srp_style_t'(pwdata[CFG_STYLE_BIT]);
         end
         if (hit(paddr, OFF_DIV)) begin
            div_nxt = clamp_div(pwdata);
         end
      end
      if (access && !pwrite && !rd_wait_r) begin
         prdata_nxt = 32'h0000_0000;
         if (hit(paddr, OFF_CTRL)) begin
            prdata_nxt[CTRL_WR_BIT] = wr_pend_r;
            prdata_nxt[CTRL_RD_BIT] = rd_pend_r;
            prdata_nxt[STAT_BUSY_BIT] = (st_r != S_IDLE);
            prdata_nxt[STAT_EMPTY_BIT] = !rd_s.valid;
         end else if (hit(paddr, OFF_OUT_CFG)) begin
            prdata_nxt[8:0] = out_len_r;
            prdata_nxt[CFG_STYLE_BIT] = out_style_r;
         end else if (hit(paddr, OFF_IN_CFG)) begin
            prdata_nxt[8:0] = in_len_r;
            prdata_nxt[CFG_STYLE_BIT] = in_style_r;
         end else if (hit(paddr, OFF_DIV)) begin
            prdata_nxt[7:0] = div_r;
         end else if (is_mem) begin
            prdata_nxt = mem_rdata;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_len_r <= LEN_RST;
         in_len_r <= LEN_RST;
         out_style_r <= rising_clock_rising_latch_style;
         in_style_r <= rising_clock_rising_latch_style;
         div_r <= DIV_RST;
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         rd_wait_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         out_len_r <= out_len_nxt;
         in_len_r <= in_len_nxt;
         out_style_r <= out_style_nxt;
         in_style_r <= in_style_nxt;
         div_r <= div_nxt;
         wr_pend_r <= wr_pend_nxt;
         rd_pend_r <= rd_pend_nxt;
         rd_wait_r <= rd_wait_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   srp_mem #(.W(DATA_W), .N(MEM_WORDS)) u_mem (
      .pclk(pclk),
      .we(mem_we),
      .waddr(widx_r),
      .wdata({word_r[30:0], sdi_s_r}),
      .raddr(paddr[4:2]),
      .rdata(mem_rdata)
   );

   // serial input passes two flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sdi_m_r <= 1'b0;
         sdi_s_r <= 1'b0;
      end else begin
         sdi_m_r <= chain_sdi;
         sdi_s_r <= sdi_m_r;
      end
   end

   // half period enable, only counts during a transfer
   assign tick = (st_r != S_IDLE) && (st_r != S_FETCH) && (cnt_r == 8'h00);
   assign start_wr = (st_r == S_IDLE) && wr_pend_r;
   assign start_rd = (st_r == S_IDLE) && !wr_pend_r && rd_pend_r;
   assign rd_s.ready = (st_r == S_FETCH);
   assign mem_we = tick && (st_r == S_LOW) && dir_in_r
                   && ((wcnt_r == 5'h1F) || (left_r == 9'h001));

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = (cnt_r == 8'h00) ? div_r - 8'h01 : cnt_r - 8'h01;
      left_nxt = left_r;
      wcnt_nxt = wcnt_r;
      widx_nxt = widx_r;
      word_nxt = word_r;
      dir_in_nxt = dir_in_r;
      sty_nxt = sty_r;
      sclk_nxt = sclk_r;
      sdo_nxt = sdo_r;
      olat_nxt = olat_r;
      iload_nxt = iload_r;
      case (st_r)
         S_IDLE: begin
            cnt_nxt = div_r - 8'h01;
            sclk_nxt = 1'b0;
            olat_nxt = (out_style_r == rising_clock_low_capture_style);
            iload_nxt = (in_style_r == rising_clock_low_capture_style);
            if (start_wr) begin
               dir_in_nxt = 1'b0;
               left_nxt = out_len_r;
               sty_nxt = out_style_r;
               st_nxt = S_FETCH;
            end else if (start_rd) begin
               dir_in_nxt = 1'b1;
               left_nxt = in_len_r;
               sty_nxt = in_style_r;
               wcnt_nxt = 5'h00;
               widx_nxt = 3'h0;
               word_nxt = 32'h0000_0000;
               cnt_nxt = HALF_MIN - 8'h01;
               iload_nxt = (in_style_r == rising_clock_rising_latch_style);
               st_nxt = S_LOAD;
            end
         end
         S_LOAD: begin
            if (tick) begin
               iload_nxt = (sty_r == rising_clock_low_capture_style);
               st_nxt = S_LOW;
            end
         end
         S_FETCH: begin
            cnt_nxt = div_r - 8'h01;
            if (rd_s.valid) begin
               sdo_nxt = rd_s.data[31];
               word_nxt = {rd_s.data[30:0], 1'b0};
               wcnt_nxt = 5'h1F;
               st_nxt = S_LOW;
            end
         end
         S_LOW: begin
            if (tick) begin
               sclk_nxt = 1'b1;
               left_nxt = left_r - 9'h001;
               if (dir_in_r) begin
                  word_nxt = mem_we ? 32'h0000_0000 : {word_r[30:0], sdi_s_r};
                  wcnt_nxt = wcnt_r + 5'h01;
                  if (mem_we) begin
                     widx_nxt = widx_r + 3'h1;
                  end
               end
               st_nxt = S_HIGH;
            end
         end
         S_HIGH: begin
            if (tick) begin
               sclk_nxt = 1'b0;
               if (left_r == 9'h000) begin
                  if (dir_in_r) begin
                     st_nxt = S_IDLE;
                  end else begin
                     olat_nxt = (sty_r == rising_clock_rising_latch_style);
                     cnt_nxt = HALF_MIN - 8'h01;
                     st_nxt = S_STROBE;
                  end
               end else if (dir_in_r) begin
                  st_nxt = S_LOW;
               end else if (wcnt_r == 5'h00) begin
                  st_nxt = S_FETCH;
               end else begin
                  sdo_nxt = word_r[31];
                  word_nxt = {word_r[30:0], 1'b0};
                  wcnt_nxt = wcnt_r - 5'h01;
                  st_nxt = S_LOW;
               end
            end
         end
         S_STROBE: begin
            if (tick) begin
               olat_nxt = (sty_r == rising_clock_low_capture_style);
               st_nxt = S_IDLE;
            end
         end
         default: begin
            st_nxt = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= S_IDLE;
         cnt_r <= 8'h00;
         left_r <= 9'h000;
         wcnt_r <= 5'h00;
         widx_r <= 3'h0;
         word_r <= 32'h0000_0000;
         dir_in_r <= 1'b0;
         sty_r <= rising_clock_rising_latch_style;
         sclk_r <= 1'b0;
         sdo_r <= 1'b0;
         olat_r <= 1'b0;
         iload_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         left_r <= left_nxt;
         wcnt_r <= wcnt_nxt;
         widx_r <= widx_nxt;
         word_r <= word_nxt;
         dir_in_r <= dir_in_nxt;
         sty_r <= sty_nxt;
         sclk_r <= sclk_nxt;
         sdo_r <= sdo_nxt;
         olat_r <= olat_nxt;
         iload_r <= iload_nxt;
      end
   end

   assign chain_sclk = sclk_r;
   assign chain_sdo = sdo_r;
   assign chain_out_latch = olat_r;
   assign chain_in_load = iload_r;
endmodule

// ==== srp_port_monitor.sv ====
// assertion checker on the pins of the shift register port
`timescale 1ns/1ps
module srp_port_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic chain_sclk,
   input wire logic chain_sdo,
   input wire logic chain_out_latch,
   input wire logic chain_sdi,
   input wire logic chain_in_load
);
   import srp_pkg::*;
   logic req_r, req_nxt, acc, mapped;
   logic [8:0] hi_r, hi_nxt;
   assign acc = psel && penable && pready;
   assign mapped = (paddr[1:0] == 2'h0 && paddr <= OFF_DIV)
                   || (paddr[11:5] == OFF_IN_DATA[11:5]);
   // remembers a chain request and counts the shift clock high phase
   always_comb begin
      req_nxt = req_r || (acc && pwrite && paddr == OFF_CTRL && pwdata[1:0] != 2'h0);
      hi_nxt = chain_sclk ? hi_r + 9'h001 : 9'h000;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_r <= 1'b0;
         hi_r <= 9'h000;
      end else begin
         req_r <= req_nxt;
         hi_r <= hi_nxt;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_sclk_high_bound: assert property (hi_r <= HALF_MAX_CYC)
      else $error("shift clock high too long");
   a_no_idle_shift: assert property ($rose(chain_sclk) |-> req_r)
      else $error("shift clock without request");
   a_sdo_held_high: assert property (chain_sclk |-> $stable(chain_sdo))
      else $error("serial out moved while clock high");
   a_latch_rise_low: assert property ($rose(chain_out_latch) |-> !chain_sclk)
      else $error("latch rose with clock high");
   a_load_quiet_clk: assert property ($changed(chain_in_load) |-> !chain_sclk)
      else $error("load strobe moved with clock high");
   a_write_no_wait: assert property (psel && penable && pwrite && paddr != OFF_OUT_DATA |-> pready)
      else $error("write not answered at once");
   a_read_one_wait: assert property ($rose(penable) && psel && !pwrite && mapped
      |-> !pready ##1 pready)
      else $error("read wait not one cycle");
   a_err_unmapped: assert property (acc |-> pslverr == !mapped)
      else $error("error response wrong for address");
endmodule

// ==== srp_chain_model.sv ====
// behavioural input and output shift register chains
`timescale 1ns/1ps
module srp_chain_model (
   input wire logic chain_sclk,
   input wire logic chain_sdo,
   input wire logic chain_out_latch,
   input wire logic chain_in_load,
   input wire logic in_style,
   input wire logic [8:0] in_len,
   input wire logic [255:0] par_in,
   output logic chain_sdi,
   output logic [255:0] out_q
);
   logic [255:0] osr = '0;
   logic [255:0] isr = '0;
   always @(posedge chain_sclk) osr <= {osr[254:0], chain_sdo};
   always @(posedge chain_out_latch) out_q <= osr;
   // loads while the strobe is active for the style, else shifts on the rise
   always @(posedge chain_sclk or posedge chain_in_load or negedge chain_in_load) begin
      if (chain_in_load != in_style) isr <= par_in;
      else if (chain_sclk) isr <= {isr[254:0], 1'b0};
   end
   assign chain_sdi = isr[in_len - 9'h001];
endmodule

// ==== srp_port_test.sv ====
// self-checking bench for the shift register port
`timescale 1ns/1ps
module srp_port_test;
   import srp_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rq;
   logic pready, pslverr, rerr, sclk, sdo, olat, sdi, iload;
   logic ist = 1'b0;
   logic [8:0] ilen = 9'h020;
   logic [255:0] par_in = '0;
   logic [255:0] out_q;
   int errors = 0;
   int cmp_count = 0;
   int rwt, t0;
   int cyc = 0;
   int ol[3] = '{32, 40, 1};
   int il[4] = '{32, 40, 256, 1};
   logic [11:0] ra[4] = '{OFF_OUT_CFG, OFF_IN_CFG, OFF_DIV, OFF_CTRL};
   logic [31:0] re[4] = '{32'h0000_0020, 32'h0000_0020, 32'h0000_0019, 32'h0000_0008};

   always #10 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;

   srp_port uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chain_sclk(sclk), .chain_sdo(sdo), .chain_out_latch(olat),
      .chain_sdi(sdi), .chain_in_load(iload));
   srp_chain_model chain (.chain_sclk(sclk), .chain_sdo(sdo), .chain_out_latch(olat),
      .chain_in_load(iload), .in_style(ist), .in_len(ilen), .par_in(par_in),
      .chain_sdi(sdi), .out_q(out_q));

   function automatic logic [31:0] wpat(input int k);
      return 32'h9C3A_51E7 ^ (32'(k) * 32'h0F1E_2D3C);
   endfunction

   task automatic chk(input string s, input logic [255:0] e, input logic [255:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask

   task automatic conclude;
      if (errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // one apb transfer, held until pready is seen high
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      rwt = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && rwt < 30000) begin
         rwt++;
         @(posedge pclk);
      end
      if (rwt >= 30000) errors++;
      rq = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic idle_wait;
      int n;
      n = 0;
      do begin
         apb(OFF_CTRL, 1'b0, 32'h0000_0000);
         n++;
      end while (rq[2:0] !== 3'h0 && n < 20000);
      if (rq[2:0] !== 3'h0) errors++;
   endtask

   task automatic out_chk(input int len, input int k0);
      logic [255:0] cat;
      cat = '0;
      for (int k = 0; k < 8; k++) cat[255 - 32 * k -: 32] = wpat(k0 + k);
      chk("out_chain", cat >> (256 - len), out_q & ({256{1'b1}} >> (256 - len)));
   endtask

   task automatic in_chk(input int len);
      int n;
      for (int k = 0; k < (len + 31) / 32; k++) begin
         n = (len - 32 * k > 32) ? 32 : len - 32 * k;
         apb(OFF_IN_DATA + 12'(4 * k), 1'b0, 32'h0000_0000);
         chk("in_word", (par_in >> (len - 32 * k - n)) & ({256{1'b1}} >> (256 - n)), rq);
      end
   endtask

   task automatic run_out(input int len, input logic st, input int k0, input logic psh);
      apb(OFF_OUT_CFG, 1'b1, {15'h0, st, 7'h0, 9'(len)});
      if (psh) begin
         for (int k = 0; k < (len + 31) / 32; k++) apb(OFF_OUT_DATA, 1'b1, wpat(k0 + k));
      end
      apb(OFF_CTRL, 1'b1, 32'h0000_0001);
      idle_wait;
      out_chk(len, k0);
   endtask

   task automatic run_in(input int len, input logic st, input logic wt);
      for (int k = 0; k < 8; k++) par_in[32 * k +: 32] = wpat(cyc + k);
      ilen = 9'(len);
      ist = st;
      apb(OFF_IN_CFG, 1'b1, {15'h0, st, 7'h0, 9'(len)});
      apb(OFF_CTRL, 1'b1, 32'h0000_0002);
      if (wt) begin
         idle_wait;
         in_chk(len);
      end
   endtask

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      foreach (ra[i]) begin
         apb(ra[i], 1'b0, 32'h0000_0000);
         chk("reset_value", re[i], rq);
      end
      apb(12'h014, 1'b0, 32'h0000_0000);
      chk("unmapped_read", 1'b1, rerr);
      apb(12'h040, 1'b1, 32'h0000_0000);
      chk("unmapped_write", 1'b1, rerr);
      apb(OFF_DIV, 1'b1, 32'h0000_0001);
      apb(OFF_DIV, 1'b0, 32'h0000_0000);
      chk("div_low", 32'h0000_0004, rq);
      foreach (ol[i]) run_out(ol[i], i[0], 8 * i, 1'b1);
      foreach (il[i]) run_in(il[i], i[0], 1'b1);
      // fifo filled during a long read, then drained by three write transfers
      run_in(256, 1'b0, 1'b0);
      apb(OFF_OUT_CFG, 1'b1, {15'h0, 1'b1, 7'h0, 9'h100});
      for (int k = 0; k < 16; k++) apb(OFF_OUT_DATA, 1'b1, wpat(100 + k));
      apb(OFF_CTRL, 1'b0, 32'h0000_0000);
      chk("full_busy", 2'b01, rq[3:2]);
      apb(OFF_CTRL, 1'b1, 32'h0000_0001);
      apb(OFF_OUT_DATA, 1'b1, wpat(116));
      chk("fifo_stall", 1'b1, rwt > 1000);
      idle_wait;
      in_chk(256);
      out_chk(256, 100);
      run_out(256, 1'b1, 108, 1'b0);
      run_out(32, 1'b0, 116, 1'b0);
      apb(OFF_CTRL, 1'b0, 32'h0000_0000);
      chk("fifo_drained", 32'h0000_0008, rq);
      apb(OFF_DIV, 1'b1, 32'h0000_00FF);
      apb(OFF_DIV, 1'b0, 32'h0000_0000);
      chk("div_high", 32'h0000_00A6, rq);
      t0 = cyc;
      run_in(32, 1'b1, 1'b1);
      chk("xfer_time", 1'b1, cyc - t0 < 10750);
      conclude;
   end

   initial begin
      repeat (60000) @(posedge pclk);
      errors++;
      conclude;
   end
endmodule

bind srp_port srp_port_monitor mon (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .chain_sclk(chain_sclk), .chain_sdo(chain_sdo),
   .chain_out_latch(chain_out_latch), .chain_sdi(chain_sdi), .chain_in_load(chain_in_load));
